// *** design/dsrp_pkg.sv ***
// Purpose: Shared constants and carriers for the codepoint remark pipeline
// Assumes: 8 ports, 8 QoS classes, 2 drop precedence levels
// Notes: Offsets are byte addresses on the AHB-Lite slave
package dsrp_pkg;

	localparam int NPORT = 8;
	localparam int PW = 3;
	localparam int CPW = 6;
	localparam int CLW = 3;
	localparam int FIFO_DEPTH = 4;
	localparam int AW = 12;

	localparam logic [AW-1:0] OFS_IGR_MODE = 12'h000;
	localparam logic [AW-1:0] OFS_EGR_ENA = 12'h004;
	localparam logic [AW-1:0] OFS_CP_ENA_LO = 12'h008;
	localparam logic [AW-1:0] OFS_CP_ENA_HI = 12'h00c;
	localparam logic [AW-1:0] OFS_STATUS = 12'h010;
	localparam logic [AW-1:0] OFS_MAP_BASE = 12'h040;
	localparam logic [AW-1:0] OFS_XL0_BASE = 12'h100;
	localparam logic [AW-1:0] OFS_XL1_BASE = 12'h200;
	localparam logic [AW-1:0] MAP_MASK = 12'hfc0;
	localparam logic [AW-1:0] XL_MASK = 12'hf00;

	localparam logic [2*NPORT-1:0] RST_IGR_MODE = 16'h0000;
	localparam logic [NPORT-1:0] RST_EGR_ENA = 8'h00;
	localparam logic [NPORT-1:0] RST_XL_ENA = 8'h00;
	localparam logic [63:0] RST_CP_ENA = 64'h0000_0000_0000_0000;
	localparam logic [CPW-1:0] RST_CP = 6'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		DSRP_MODE_OFF = 2'h0,
		DSRP_MODE_ZERO = 2'h1,
		DSRP_MODE_TABLE = 2'h2,
		DSRP_MODE_ALL = 2'h3
	} dsrp_mode_t;

	typedef struct packed {
		logic [PW-1:0] igr_port;
		logic [PW-1:0] egr_port;
		logic [CPW-1:0] cp;
		logic is_v4;
		logic is_v6;
		logic [CLW-1:0] qos_class;
		logic dp;
		logic tcam_hit;
		logic tcam_cp_ena;
		logic [CPW-1:0] tcam_cp;
		logic [15:0] csum;
	} dsrp_frm_in_t;

	typedef struct packed {
		logic [PW-1:0] egr_port;
		logic [CPW-1:0] cp_old;
		logic [CPW-1:0] cp_new;
		logic remark;
		logic is_v4;
		logic dp;
		logic [15:0] csum;
	} dsrp_carry_t;

	typedef struct packed {
		logic [PW-1:0] egr_port;
		logic [CPW-1:0] cp;
		logic [15:0] csum;
		logic rewritten;
	} dsrp_frm_out_t;

endpackage

// *** design/dsrp_fifo.sv ***
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Read data comes straight from the storage flops
`timescale 1ns/1ps
`default_nettype none
module dsrp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import dsrp_pkg::*;

	localparam int PA = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PA:0] wp;
		logic [PA:0] rp;
	} dsrp_fifo_st_t;

	dsrp_fifo_st_t q;
	dsrp_fifo_st_t d;
	logic full;
	logic empty;

	// Extra pointer bit tells full from empty
	assign full = (q.wp[PA] != q.rp[PA]) && (q.wp[PA-1:0] == q.rp[PA-1:0]);
	assign empty = (q.wp == q.rp);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = q.mem[q.rp[PA-1:0]];

	always_comb begin
		d = q;
		if (in_valid && !full) begin
			d.mem[q.wp[PA-1:0]] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			d.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule
`default_nettype wire

// *** design/dsrp_remark.sv ***
// Purpose: Per-frame codepoint remark decision at ingress and rewrite at egress
// Assumes: One descriptor per frame, header fields already parsed upstream
// Notes: AHB-Lite slave, writes zero wait, reads one wait state
// What this block does
// - Codepoint is a six-bit field
// - Two-bit remark mode held per ingress port
// - Mode 0 selects no frame, classifier override still applies
// - Mode 1 selects only codepoint zero
// - Mode 2 uses shared per-codepoint enable table
// - Mode 3 selects every frame
// - New codepoint from class and drop precedence
// - Classifier action codepoint overrides table value
// - Decision and codepoint travel to egress stage
// - Egress writes only where port enable set
// - Optional translation by drop precedence table
// - IPv4 rewrite recomputes header checksum
// - Codepoints 0 to 63 index tables
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dsrp_remark (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Frame descriptors from the classifier
	input wire logic frm_in_valid,
	output logic frm_in_ready,
	input wire dsrp_pkg::dsrp_frm_in_t frm_in,
	// Frame descriptors to the frame rewriter
	output logic frm_out_valid,
	input wire logic frm_out_ready,
	output dsrp_pkg::dsrp_frm_out_t frm_out
);
	import dsrp_pkg::*;

	localparam int CW = $bits(dsrp_carry_t);

	typedef struct packed {
		logic [2*NPORT-1:0] igr_mode;
		logic [NPORT-1:0] egr_ena;
		logic [NPORT-1:0] xl_ena;
		logic [63:0] cp_ena;
		logic [15:0][CPW-1:0] cp_map;
		logic [1:0][63:0][CPW-1:0] xl;
		logic [15:0] count;
		logic dp_act;
		logic dp_wr;
		logic [AW-1:0] dp_addr;
		logic rd_wait;
		logic [31:0] rdata;
		logic out_vld;
		dsrp_frm_out_t out;
	} dsrp_regs_t;

	dsrp_regs_t q;
	dsrp_regs_t d;

	dsrp_carry_t ing;
	dsrp_carry_t egr;
	logic fifo_vld;
	logic fifo_rdy;
	logic [CW-1:0] fifo_out;
	logic pop;

	// Incremental update: only the codepoint bits of the first header word change
	function automatic logic [15:0] dsrp_csum(input logic [15:0] hc, input logic [CPW-1:0] o,
		input logic [CPW-1:0] n);
		logic [17:0] s;
		s = {2'b00, ~hc} + {2'b00, ~{8'h00, o, 2'b00}} + {2'b00, 8'h00, n, 2'b00};
		s = {2'b00, s[15:0]} + {16'h0000, s[17:16]};
		s = {2'b00, s[15:0]} + {16'h0000, s[17:16]};
		return ~s[15:0];
	endfunction

	function automatic logic [31:0] dsrp_rd(input dsrp_regs_t r, input logic [AW-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == OFS_IGR_MODE) begin
			v[2*NPORT-1:0] = r.igr_mode;
		end else if (a == OFS_EGR_ENA) begin
			v[15:0] = {r.xl_ena, r.egr_ena};
		end else if (a == OFS_CP_ENA_LO) begin
			v = r.cp_ena[31:0];
		end else if (a == OFS_CP_ENA_HI) begin
			v = r.cp_ena[63:32];
		end else if (a == OFS_STATUS) begin
			v[15:0] = r.count;
		end else if ((a & MAP_MASK) == OFS_MAP_BASE) begin
			v[CPW-1:0] = r.cp_map[a[5:2]];
		end else if ((a & XL_MASK) == OFS_XL0_BASE) begin
			v[CPW-1:0] = r.xl[0][a[7:2]];
		end else if ((a & XL_MASK) == OFS_XL1_BASE) begin
			v[CPW-1:0] = r.xl[1][a[7:2]];
		end
		return v;
	endfunction

	// Ingress decision, combinational ahead of the FIFO
	always_comb begin
		logic [1:0] mode;
		logic sel;
		logic ovr;
		mode = q.igr_mode[{frm_in.igr_port, 1'b0} +: 2];
		sel = 1'b0;
		ovr = 1'b0;
		case (dsrp_mode_t'(mode))
			DSRP_MODE_OFF: begin
				sel = 1'b0;
			end
			DSRP_MODE_ZERO: begin
				sel = (frm_in.cp == RST_CP);
			end
			DSRP_MODE_TABLE: begin
				sel = q.cp_ena[frm_in.cp];
			end
			DSRP_MODE_ALL: begin
				sel = 1'b1;
			end
			default: begin
				sel = 1'b0;
			end
		endcase
		ovr = frm_in.tcam_hit && frm_in.tcam_cp_ena;
		ing.egr_port = frm_in.egr_port;
		ing.cp_old = frm_in.cp;
		ing.cp_new = ovr ? frm_in.tcam_cp : q.cp_map[{frm_in.qos_class, frm_in.dp}];
		// Non-IP frames carry no codepoint to touch
		ing.remark = (sel || ovr) && (frm_in.is_v4 || frm_in.is_v6);
		ing.is_v4 = frm_in.is_v4;
		ing.dp = frm_in.dp;
		ing.csum = frm_in.csum;
	end

	// Decision rides with the frame to the egress stage
	dsrp_fifo #(
		.W(CW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(frm_in_valid),
		.in_ready(fifo_rdy),
		.in_data(ing),
		.out_valid(fifo_vld),
		.out_ready(pop),
		.out_data(fifo_out)
	);

	assign frm_in_ready = fifo_rdy;
	assign egr = dsrp_carry_t'(fifo_out);
	// Output stall backs up into the FIFO and then the classifier
	assign pop = !q.out_vld || frm_out_ready;

	assign hreadyout = !q.rd_wait;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign frm_out_valid = q.out_vld;
	assign frm_out = q.out;

	always_comb begin
		logic wr;
		logic [CPW-1:0] v;
		logic [31:0] w;
		logic [AW-1:0] a;
		d = q;
		w = hwdata;
		a = q.dp_addr;
		wr = 1'b0;
		v = '0;

		// Register writes in the data phase
		if (q.dp_act && q.dp_wr) begin
			if (a == OFS_IGR_MODE) begin
				d.igr_mode = w[2*NPORT-1:0];
			end else if (a == OFS_EGR_ENA) begin
				d.egr_ena = w[NPORT-1:0];
				d.xl_ena = w[2*NPORT-1:NPORT];
			end else if (a == OFS_CP_ENA_LO) begin
				d.cp_ena[31:0] = w;
			end else if (a == OFS_CP_ENA_HI) begin
				d.cp_ena[63:32] = w;
			end else if ((a & MAP_MASK) == OFS_MAP_BASE) begin
				d.cp_map[a[5:2]] = w[CPW-1:0];
			end else if ((a & XL_MASK) == OFS_XL0_BASE) begin
				d.xl[0][a[7:2]] = w[CPW-1:0];
			end else if ((a & XL_MASK) == OFS_XL1_BASE) begin
				d.xl[1][a[7:2]] = w[CPW-1:0];
			end
		end

		// Read data fetched in the wait cycle, after any earlier write landed
		if (q.rd_wait) begin
			d.rdata = dsrp_rd(q, a);
			d.rd_wait = 1'b0;
			d.dp_act = 1'b0;
		end else if (hready) begin
			d.dp_act = hsel && htrans[1];
			d.dp_wr = hsel && htrans[1] && hwrite && (hsize == HSIZE_WORD);
			d.dp_addr = haddr[AW-1:0];
			d.rd_wait = hsel && htrans[1] && !hwrite;
		end

		// Egress rewrite stage
		wr = egr.remark && q.egr_ena[egr.egr_port];
		v = q.xl_ena[egr.egr_port] ? q.xl[egr.dp][egr.cp_new] : egr.cp_new;
		if (pop) begin
			d.out_vld = fifo_vld;
			if (fifo_vld) begin
				d.out.egr_port = egr.egr_port;
				d.out.rewritten = wr;
				d.out.cp = wr ? v : egr.cp_old;
				d.out.csum = (wr && egr.is_v4) ? dsrp_csum(egr.csum, egr.cp_old, v) : egr.csum;
				if (wr) begin
					d.count = q.count + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.igr_mode <= RST_IGR_MODE;
			q.egr_ena <= RST_EGR_ENA;
			q.xl_ena <= RST_XL_ENA;
			q.cp_ena <= RST_CP_ENA;
			q.count <= RST_COUNT;
		end else begin
			q <= d;
		end
	end

endmodule
`default_nettype wire

// *** verif/dsrp_remark_sva.sv ***
// Purpose: Port checker for dsrp_remark
// Assumes: Single slave, hready fed back from hreadyout
// Notes: Bound below the module
`timescale 1ns/1ps
`default_nettype none
module dsrp_remark_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Frames
	input wire logic frm_in_valid,
	input wire logic frm_in_ready,
	input wire logic frm_out_valid,
	input wire logic frm_out_ready,
	input wire dsrp_pkg::dsrp_frm_out_t frm_out
);
	import dsrp_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait");
	chk_write_fast: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write wait");
	chk_one_wait: assert property (!hreadyout |=> hreadyout)
		else $error("long wait");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("bad resp");
	chk_out_hold: assert property (frm_out_valid && !frm_out_ready |=> frm_out_valid && $stable(frm_out))
		else $error("output moved");
	chk_in_flow: assert property (frm_in_valid && frm_in_ready |-> ##[1:8] frm_out_valid)
		else $error("frame lost");
	chk_full_hold: assert property (!frm_in_ready && frm_out_valid && !frm_out_ready |=> !frm_in_ready)
		else $error("full freed");
	chk_idle_start: assert property ($rose(rst_n) |-> !frm_out_valid && frm_in_ready)
		else $error("not idle");
	cov_read: cover property (hsel && hready && htrans[1] && !hwrite);
	cov_full: cover property (!frm_in_ready);
	cov_rewrite: cover property (frm_out_valid && frm_out_ready && frm_out.rewritten);
endmodule
bind dsrp_remark dsrp_remark_sva u_sva (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .frm_in_valid(frm_in_valid),
	.frm_in_ready(frm_in_ready), .frm_out_valid(frm_out_valid), .frm_out_ready(frm_out_ready), .frm_out(frm_out));
`default_nettype wire

// *** verif/dsrp_sink.sv ***
// Purpose: Frame rewriter stand-in taking output descriptors
// Assumes: Bench may stall it
// Notes: Taken descriptors queue up for the bench
`timescale 1ns/1ps
`default_nettype none
module dsrp_sink (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire logic stall,
	// Descriptors
	input wire logic frm_out_valid,
	input wire dsrp_pkg::dsrp_frm_out_t frm_out,
	output logic frm_out_ready
);
	import dsrp_pkg::*;
	dsrp_frm_out_t got[$];
	// Registered ready, so a stall lands one edge late
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frm_out_ready <= 1'b0;
		end else begin
			frm_out_ready <= !stall;
			if (frm_out_valid && frm_out_ready) begin
				got.push_back(frm_out);
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench for dsrp_remark
// Assumes: One slave, sink model on the output
// Notes: Frames enter on port 0, one frame in t_ports on port 3
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dsrp_pkg::*;
	logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, frm_in_valid = 0, stall = 0;
	logic [31:0] haddr = 0, hwdata = 0, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = HSIZE_WORD;
	wire logic hready, hresp, frm_in_ready, frm_out_valid, frm_out_ready;
	wire logic [31:0] hrdata;
	dsrp_frm_in_t frm_in = '0;
	wire dsrp_frm_out_t frm_out;
	int n_mismatch = 0, num_checks = 0;
	always #5 mclk = ~mclk;
	dsrp_remark u_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.frm_in_valid(frm_in_valid), .frm_in_ready(frm_in_ready), .frm_in(frm_in), .frm_out_valid(frm_out_valid),
		.frm_out_ready(frm_out_ready), .frm_out(frm_out));
	dsrp_sink u_sink (.mclk(mclk), .rst_n(rst_n), .stall(stall), .frm_out_valid(frm_out_valid),
		.frm_out(frm_out), .frm_out_ready(frm_out_ready));
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(string nm, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	task bus(logic w, logic [11:0] a, logic [31:0] d);
		hsel <= 1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(negedge mclk); while (hready !== 1'b1);
		@(posedge mclk);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(negedge mclk); while (hready !== 1'b1);
		q = hrdata;
		@(posedge mclk);
	endtask
	task send(dsrp_frm_in_t f);
		frm_in_valid <= 1;
		frm_in <= f;
		do @(negedge mclk); while (frm_in_ready !== 1'b1);
		@(posedge mclk);
		frm_in_valid <= 0;
	endtask
	task take(dsrp_frm_out_t e);
		for (int i = 0; i < 40 && u_sink.got.size() == 0; i++) @(negedge mclk);
		if (u_sink.got.size() == 0) chk("no frame", 0, 1);
		else chk("frm_out", u_sink.got.pop_front(), e);
		@(posedge mclk);
	endtask
	function automatic logic [15:0] cs(logic [15:0] h, logic [5:0] o, logic [5:0] n);
		logic [17:0] s;
		s = {2'h0, ~h} + {2'h0, ~{8'h00, o, 2'h0}} + {10'h0, n, 2'h0};
		s = {2'h0, s[15:0]} + s[17:16];
		s = {2'h0, s[15:0]} + s[17:16];
		return ~s[15:0];
	endfunction
	function automatic dsrp_frm_out_t ex(dsrp_frm_in_t f, logic s, logic [5:0] n);
		return {f.egr_port, s ? n : f.cp, s && f.is_v4 ? cs(f.csum, f.cp, n) : f.csum, s};
	endfunction
	function automatic dsrp_frm_in_t fr(logic [2:0] e, logic [5:0] c, logic d, logic h, logic [5:0] t);
		fr = '0;
		fr.egr_port = e;
		fr.cp = c;
		fr.is_v4 = 1;
		fr.qos_class = 3'h2;
		fr.dp = d;
		fr.tcam_hit = h;
		fr.tcam_cp_ena = h;
		fr.tcam_cp = t;
		fr.csum = 16'hb1e5;
	endfunction
	task t_regs;
		bus(0, 12'h000, 0);
		chk("mode rst", q, 0);
		bus(1, 12'h000, 32'hc3a5);
		bus(0, 12'h000, 0);
		chk("mode rw", q, 32'hc3a5);
		// Narrow writes must leave the register alone
		hsize <= 3'h0;
		bus(1, 12'h000, 32'hffff);
		hsize <= HSIZE_WORD;
		bus(0, 12'h000, 0);
		chk("narrow wr", q, 32'hc3a5);
		bus(0, 12'h800, 0);
		chk("unmapped", q, 0);
	endtask
	task t_modes;
		logic s;
		logic [5:0] c;
		bus(1, 12'h050, 32'h2a);
		bus(1, 12'h004, 32'h2);
		bus(1, 12'h00c, 32'h20);
		for (int m = 0; m < 4; m++) begin
			bus(1, 12'h000, m);
			for (int k = 0; k < 3; k++) begin
				c = k == 0 ? 6'h00 : k == 1 ? 6'h25 : 6'h05;
				s = m == 3 || (m == 1 && c == 0) || (m == 2 && c == 6'h25);
				send(fr(1, c, 0, 0, 0));
				take(ex(fr(1, c, 0, 0, 0), s, 6'h2a));
			end
		end
		send(fr(2, 6'h05, 0, 0, 0));
		take(ex(fr(2, 6'h05, 0, 0, 0), 0, 0));
	endtask
	task t_tcam;
		dsrp_frm_in_t f;
		bus(1, 12'h000, 0);
		f = fr(1, 6'h07, 0, 1, 6'h11);
		send(f);
		take(ex(f, 1, 6'h11));
		f.is_v4 = 0;
		f.is_v6 = 1;
		send(f);
		take(ex(f, 1, 6'h11));
		bus(1, 12'h004, 32'h202);
		bus(1, 12'h2a8, 32'h15);
		f = fr(1, 6'h07, 1, 1, 6'h2a);
		send(f);
		take(ex(f, 1, 6'h15));
	endtask
	task t_ports;
		dsrp_frm_in_t f;
		bus(0, 12'h010, 0);
		chk("count", q, 32'h8);
		bus(1, 12'h1a8, 32'h33);
		bus(1, 12'h000, 32'hc0);
		f = fr(1, 6'h05, 0, 0, 0);
		f.igr_port = 3;
		send(f);
		take(ex(f, 1, 6'h33));
		f.igr_port = 0;
		send(f);
		take(ex(f, 0, 0));
		// Override on a non-IP frame has nothing to rewrite
		f = fr(1, 6'h07, 0, 1, 6'h11);
		f.is_v4 = 0;
		send(f);
		take(ex(f, 0, 0));
		// Hit without codepoint enable gives no override
		f = fr(1, 6'h07, 0, 1, 6'h11);
		f.tcam_cp_ena = 0;
		send(f);
		take(ex(f, 0, 0));
		bus(1, 12'h008, 32'h80);
		bus(1, 12'h000, 32'h2);
		send(f);
		take(ex(f, 1, 6'h33));
		bus(0, 12'h010, 0);
		chk("count", q, 32'ha);
		bus(1, 12'h000, 0);
	endtask
	task t_stall;
		stall <= 1;
		for (int i = 0; i < 5; i++) begin
			send(fr(1, 6'(i), 0, 0, 0));
			@(posedge mclk);
		end
		@(negedge mclk);
		chk("in ready", frm_in_ready, 0);
		@(posedge mclk);
		stall <= 0;
		for (int i = 0; i < 5; i++) take(ex(fr(1, 6'(i), 0, 0, 0), 0, 0));
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1;
		t_regs;
		t_modes;
		t_tcam;
		t_ports;
		t_stall;
		final_report;
	end
	initial begin
		#100000;
		n_mismatch++;
		final_report;
	end
endmodule
`default_nettype wire
